/* design/rx_frame_status_word_a.sv */
// Receive status word builder with its classic Wishbone register slave and interrupt.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Group flag bit 24 when address group bit set, never for all-ones broadcast.
// - Bit 23 when VLAN tag removed; removed tag goes out for second word.
// - Error summary bit 22 is OR of FCS, alignment, PHY, long, runt, timeout, checksums.
// - Bit 21 when MAC cut the frame beyond 11,264 bytes.
// - Bit 20 for frames under 64 bytes and for any short frame.
// - Runt frames pass only with keep-bad set, otherwise dropped.
// - Bit 19 when length exceeds programmed maximum; reception is not truncated.
// - Bit 18 when PHY receive error seen at any time during the frame.
// - Bit 17 for odd bit count with FCS error, only at 10/100.
// - Bit 16 on FCS mismatch or on PHY receive error during frame.
// - FCS bit carries no meaning for runt or timed-out frames.
// - Bit 15 for a unicast destination.
// - Bit 14 when L4 checksum could not be computed; L4 error then ignored.
// - Bits 13 to 0 hold the received frame length in bytes.
// - With FCS stripping enabled the reported length is four bytes less for frames of four bytes or more.
// - Bit 31 carries IP header checksum error, not for IPv6.
// - Keep-bad control decides whether frames with non-checksum errors are kept or dropped.
// - Bit 25 is broadcast flag, exclusive with the group flag.
module rx_frame_status_word_a #(
    parameter int MAX_SIZE_W = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Frame status from MAC and filter engine
    input wire logic frame_start,
    input wire logic byte_strobe,
    input wire logic phy_symbol_error,
    input wire logic gigabit_mode,
    input wire logic frame_end,
    input wire rx_status_pkg::frame_end_t frame_info,
    // Status toward the FIFO controller
    output rx_status_pkg::status_out_t status_out,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (MAX_SIZE_W != rx_status_pkg::LEN_W) begin : g_bad_width
        $error("MAX_SIZE_W must equal the length field width");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RECV = 2'b10
    } rx_state_t;

    // ------------------------------------------------------------
    // State declarations
    // ------------------------------------------------------------
    rx_state_t state_reg;
    rx_state_t state_next;
    logic [MAX_SIZE_W-1:0] count_reg;
    logic [MAX_SIZE_W-1:0] count_next;
    logic phy_seen_reg;
    logic phy_seen_next;
    rx_status_pkg::status_out_t out_reg;
    rx_status_pkg::status_out_t out_next;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] last_word_reg;
    logic [31:0] last_word_next;
    logic [31:0] frame_count_reg;
    logic [31:0] frame_count_next;
    logic [rx_status_pkg::EVT_W-1:0] int_status_reg;
    logic [rx_status_pkg::EVT_W-1:0] int_status_next;
    logic [rx_status_pkg::EVT_W-1:0] int_mask_reg;
    logic [rx_status_pkg::EVT_W-1:0] int_mask_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    logic irq_reg;
    logic irq_next;

    // ------------------------------------------------------------
    // Control fields and per-frame flag evaluation
    // ------------------------------------------------------------
    logic keep_bad;
    logic strip_fcs;
    logic [MAX_SIZE_W-1:0] max_size;
    logic [MAX_SIZE_W-1:0] total_len;
    logic [MAX_SIZE_W-1:0] report_len;
    logic is_all_ones;
    logic is_group;
    logic is_single;
    logic is_runt;
    logic is_long;
    logic phy_err;
    logic fcs_err;
    logic odd_err;
    logic l4_err;
    logic any_err;
    logic drop_frame;
    logic [rx_status_pkg::EVT_W-1:0] events;
    logic [31:0] word;

    assign keep_bad = ctrl_reg[rx_status_pkg::KEEP_BAD_BIT];
    assign strip_fcs = ctrl_reg[rx_status_pkg::STRIP_FCS_BIT];
    assign max_size = ctrl_reg[rx_status_pkg::MAX_SIZE_LSB +: MAX_SIZE_W];

    always_comb begin
        // The ending byte may share the cycle with the end strobe.
        if (byte_strobe && count_reg != rx_status_pkg::LEN_SATURATE) begin
            total_len = count_reg + 14'h0001;
        end else begin
            total_len = count_reg;
        end
        if (strip_fcs && total_len >= rx_status_pkg::FCS_BYTES) begin
            report_len = total_len - rx_status_pkg::FCS_BYTES;
        end else begin
            report_len = total_len;
        end
        is_all_ones = &frame_info.dest_addr;
        is_group = frame_info.dest_addr[rx_status_pkg::GROUP_ADDR_BIT] && !is_all_ones;
        is_single = !frame_info.dest_addr[rx_status_pkg::GROUP_ADDR_BIT];
        is_runt = total_len < rx_status_pkg::MIN_FRAME_BYTES || frame_info.short_seen;
        is_long = total_len > max_size;
        phy_err = phy_seen_reg || phy_symbol_error;
        // The check result is passed as seen; it is not meaningful for runt or cut frames.
        fcs_err = frame_info.fcs_mismatch || phy_err;
        odd_err = frame_info.odd_bit_count && fcs_err && !gigabit_mode;
        l4_err = frame_info.l4_sum_error && !frame_info.l4_sum_unknown;
        any_err = fcs_err || odd_err || phy_err || is_long || is_runt
            || frame_info.timeout_cut || frame_info.ip_sum_error || l4_err;
        // Checksum errors never cause a drop; such frames are dropped only for another error with keep-bad clear.
        drop_frame = !keep_bad && (fcs_err || odd_err || phy_err || is_long
            || is_runt || frame_info.timeout_cut);
        word = 32'h0000_0000;
        word[rx_status_pkg::IP_HDR_SUM_ERR_BIT] = frame_info.ip_sum_error;
        word[rx_status_pkg::ALL_ONES_BIT] = is_all_ones;
        word[rx_status_pkg::GROUP_BIT] = is_group;
        word[rx_status_pkg::VLAN_BIT] = frame_info.vlan_removed;
        word[rx_status_pkg::ANY_ERR_BIT] = any_err;
        word[rx_status_pkg::TIMEOUT_BIT] = frame_info.timeout_cut;
        word[rx_status_pkg::RUNT_BIT] = is_runt;
        word[rx_status_pkg::LONG_BIT] = is_long;
        word[rx_status_pkg::PHY_ERR_BIT] = phy_err;
        word[rx_status_pkg::ODD_BITS_BIT] = odd_err;
        word[rx_status_pkg::FCS_BIT] = fcs_err;
        word[rx_status_pkg::SINGLE_BIT] = is_single;
        word[rx_status_pkg::L4_UNKNOWN_BIT] = frame_info.l4_sum_unknown;
        word[MAX_SIZE_W-1:0] = report_len;
    end

    // ------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        phy_seen_next = phy_seen_reg;
        out_next = out_reg;
        out_next.valid = 1'b0;
        events = '0;
        case (state_reg)
            ST_IDLE: begin
                if (frame_start) begin
                    state_next = ST_RECV;
                    count_next = '0;
                    phy_seen_next = phy_symbol_error;
                end
            end
            ST_RECV: begin
                // The counter saturates so an overlong frame still reports a sane length.
                if (byte_strobe && count_reg != rx_status_pkg::LEN_SATURATE) begin
                    count_next = count_reg + 14'h0001;
                end
                if (phy_symbol_error) begin
                    phy_seen_next = 1'b1;
                end
                if (frame_end) begin
                    state_next = ST_IDLE;
                    out_next.valid = 1'b1;
                    out_next.drop = drop_frame;
                    out_next.word = word;
                    out_next.vlan_tag = frame_info.vlan_tag;
                    events[rx_status_pkg::EVT_DONE] = 1'b1;
                    events[rx_status_pkg::EVT_ERROR] = any_err;
                    events[rx_status_pkg::EVT_DROP] = drop_frame;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
            phy_seen_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            phy_seen_reg <= phy_seen_next;
            out_reg <= out_next;
        end
    end

    // ------------------------------------------------------------
    // Wishbone registers and interrupt
    // ------------------------------------------------------------
    logic bus_req;
    logic [31:0] byte_mask;
    logic [31:0] write_mask;

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign byte_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end

    assign write_mask = byte_mask & rx_status_pkg::CTRL_WRITABLE;

    always_comb begin
        ctrl_next = ctrl_reg;
        int_mask_next = int_mask_reg;
        int_status_next = int_status_reg;
        last_word_next = last_word_reg;
        frame_count_next = frame_count_reg;
        rdata_next = rdata_reg;
        ack_next = bus_req;
        if (out_reg.valid) begin
            last_word_next = out_reg.word;
            frame_count_next = frame_count_reg + 32'h0000_0001;
        end
        if (bus_req && wb_we_i) begin
            case (wb_adr_i)
                rx_status_pkg::CTRL_OFFSET: begin
                    ctrl_next = (ctrl_reg & ~write_mask) | (wb_dat_i & write_mask);
                end
                rx_status_pkg::INT_STATUS_OFFSET: begin
                    if (wb_sel_i[0]) begin
                        int_status_next = int_status_reg & ~wb_dat_i[rx_status_pkg::EVT_W-1:0];
                    end
                end
                rx_status_pkg::INT_MASK_OFFSET: begin
                    if (wb_sel_i[0]) begin
                        int_mask_next = wb_dat_i[rx_status_pkg::EVT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // A new event wins over a clear landing in the same cycle.
        int_status_next = int_status_next | events;
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                rx_status_pkg::CTRL_OFFSET: rdata_next = ctrl_reg;
                rx_status_pkg::LAST_WORD_OFFSET: rdata_next = last_word_reg;
                rx_status_pkg::INT_STATUS_OFFSET: rdata_next = {29'h0000_0000, int_status_reg};
                rx_status_pkg::INT_MASK_OFFSET: rdata_next = {29'h0000_0000, int_mask_reg};
                rx_status_pkg::FRAME_COUNT_OFFSET: rdata_next = frame_count_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        irq_next = |(int_status_next & int_mask_next);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= rx_status_pkg::CTRL_RESET;
            int_mask_reg <= '0;
            int_status_reg <= '0;
            last_word_reg <= 32'h0000_0000;
            frame_count_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            int_mask_reg <= int_mask_next;
            int_status_reg <= int_status_next;
            last_word_reg <= last_word_next;
            frame_count_reg <= frame_count_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            irq_reg <= irq_next;
        end
    end

    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
    assign status_out = out_reg;
    assign irq = irq_reg;
endmodule : rx_frame_status_word_a
`default_nettype wire

/* pkg/rx_status_pkg.sv */
// Package with constants, layouts and carrier types for the receive status word builder.
package rx_status_pkg;
    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int IP_HDR_SUM_ERR_BIT = 31;
    localparam int ALL_ONES_BIT = 25;
    localparam int GROUP_BIT = 24;
    localparam int VLAN_BIT = 23;
    localparam int ANY_ERR_BIT = 22;
    localparam int TIMEOUT_BIT = 21;
    localparam int RUNT_BIT = 20;
    localparam int LONG_BIT = 19;
    localparam int PHY_ERR_BIT = 18;
    localparam int ODD_BITS_BIT = 17;
    localparam int FCS_BIT = 16;
    localparam int SINGLE_BIT = 15;
    localparam int L4_UNKNOWN_BIT = 14;
    localparam int LEN_W = 14;
    localparam int GROUP_ADDR_BIT = 40;
    localparam logic [LEN_W-1:0] MIN_FRAME_BYTES = 14'h0040;
    localparam logic [LEN_W-1:0] FCS_BYTES = 14'h0004;
    localparam logic [LEN_W-1:0] LEN_SATURATE = 14'h3FFF;
    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [4:0] CTRL_OFFSET = 5'h00;
    localparam logic [4:0] LAST_WORD_OFFSET = 5'h04;
    localparam logic [4:0] INT_STATUS_OFFSET = 5'h08;
    localparam logic [4:0] INT_MASK_OFFSET = 5'h0C;
    localparam logic [4:0] FRAME_COUNT_OFFSET = 5'h10;
    localparam int KEEP_BAD_BIT = 0;
    localparam int STRIP_FCS_BIT = 1;
    localparam int MAX_SIZE_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h05EE_0000;
    localparam logic [31:0] CTRL_WRITABLE = 32'h3FFF_0003;
    localparam int EVT_W = 3;
    localparam int EVT_DONE = 0;
    localparam int EVT_ERROR = 1;
    localparam int EVT_DROP = 2;
    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [47:0] dest_addr;
        logic vlan_removed;
        logic [15:0] vlan_tag;
        logic fcs_mismatch;
        logic odd_bit_count;
        logic timeout_cut;
        logic short_seen;
        logic ip_sum_error;
        logic l4_sum_error;
        logic l4_sum_unknown;
    } frame_end_t;
    typedef struct packed {
        logic valid;
        logic drop;
        logic [31:0] word;
        logic [15:0] vlan_tag;
    } status_out_t;
endpackage : rx_status_pkg

/* test/rx_status_properties.sv */
// Checker of bus timing and status word relations for the status word builder.
`timescale 1ns/1ps
`default_nettype none
module rx_status_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic gigabit_mode,
    input wire logic frame_end,
    input wire rx_status_pkg::frame_end_t frame_info,
    input wire rx_status_pkg::status_out_t status_out
);
    wire logic v = status_out.valid;
    wire logic [31:0] w = status_out.word;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack;
        s_take |=> s_pulse;
    endproperty
    property p_valid;
        v |-> $past(frame_end) ##1 !v;
    endproperty
    property p_group;
        v |-> w[24] == ($past(frame_info.dest_addr[40]) && !(&$past(frame_info.dest_addr)));
    endproperty
    property p_onehot;
        v |-> $onehot({w[25], w[24], w[15]});
    endproperty
    property p_single;
        v |-> w[15] == !$past(frame_info.dest_addr[40]);
    endproperty
    property p_sum;
        v && (|{w[31], w[21:16]}) |-> w[22];
    endproperty
    property p_phy_fcs;
        v && w[18] |-> w[16];
    endproperty
    property p_gig;
        v && $past(gigabit_mode) |-> !w[17];
    endproperty
    property p_vlan;
        v |-> w[23] == $past(frame_info.vlan_removed)
            && (!w[23] || status_out.vlan_tag == $past(frame_info.vlan_tag));
    endproperty
    property p_timeout;
        v |-> w[21] == $past(frame_info.timeout_cut);
    endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
    a_valid: assert property (p_valid) else $error("valid not one cycle after frame end");
    a_group: assert property (p_group) else $error("group flag wrong");
    a_onehot: assert property (p_onehot) else $error("address flags not one-hot");
    a_single: assert property (p_single) else $error("unicast flag wrong");
    a_sum: assert property (p_sum) else $error("error summary missing");
    a_phy_fcs: assert property (p_phy_fcs) else $error("phy error without fcs flag");
    a_gig: assert property (p_gig) else $error("odd bits flag at gigabit");
    a_vlan: assert property (p_vlan) else $error("vlan flag or tag wrong");
    a_timeout: assert property (p_timeout) else $error("timeout flag wrong");
endmodule : rx_status_properties
bind rx_frame_status_word_a rx_status_properties chk (.clk(clk), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .gigabit_mode(gigabit_mode), .frame_end(frame_end), .frame_info(frame_info),
    .status_out(status_out));
`default_nettype wire

/* test/mac_model.sv */
// Behavioural MAC and filter engine that feeds frames to the status word builder.
`timescale 1ns/1ps
`default_nettype none
module mac_model (
    // Clock
    input wire logic clk,
    // Frame link
    output logic frame_start,
    output logic byte_strobe,
    output logic phy_symbol_error,
    output logic frame_end,
    output rx_status_pkg::frame_end_t frame_info
);
    initial begin
        frame_start = 1'b0;
        byte_strobe = 1'b0;
        phy_symbol_error = 1'b0;
        frame_end = 1'b0;
        frame_info = '0;
    end
    // Once the frame ends the status lines show the inverted value, so a late sample fails.
    task automatic send(input int n, input rx_status_pkg::frame_end_t fi, input logic pe);
        @(posedge clk);
        frame_start <= 1'b1;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            frame_start <= 1'b0;
            byte_strobe <= 1'b1;
            phy_symbol_error <= pe && (i == n / 2);
            frame_end <= (i == n);
            frame_info <= (i == n) ? fi : ~fi;
        end
        @(posedge clk);
        byte_strobe <= 1'b0;
        frame_end <= 1'b0;
        phy_symbol_error <= 1'b0;
        frame_info <= ~fi;
    endtask : send
endmodule : mac_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the receive status word builder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [47:0] UC = 48'h0200_0000_0001;
    localparam logic [47:0] MC = 48'h0100_5E00_0001;
    localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
    logic clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, gigabit_mode, wb_ack_o, irq;
    logic frame_start, byte_strobe, phy_symbol_error, frame_end;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    rx_status_pkg::frame_end_t frame_info;
    rx_status_pkg::status_out_t status_out, st;
    int fail_count = 0;
    int compares = 0;
    logic [7:0] ef [9] = '{8'h40, 8'h00, 8'h60, 8'h60, 8'h10, 8'h08, 8'h04, 8'h02, 8'h03};
    logic [2:0] em [9] = '{3'h1, 3'h5, 3'h1, 3'h3, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
    logic [31:0] ew [9] = '{32'h0041_0000, 32'h0045_0000, 32'h0043_0000, 32'h0041_0000,
        32'h0060_0000, 32'h0050_0000, 32'h8040_0000, 32'h0040_0000, 32'h0000_4000};
    rx_frame_status_word_a dut (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .frame_start(frame_start), .byte_strobe(byte_strobe),
        .phy_symbol_error(phy_symbol_error), .gigabit_mode(gigabit_mode),
        .frame_end(frame_end), .frame_info(frame_info), .status_out(status_out), .irq(irq));
    mac_model mac (.clk(clk), .frame_start(frame_start), .byte_strobe(byte_strobe),
        .phy_symbol_error(phy_symbol_error), .frame_end(frame_end), .frame_info(frame_info));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hF);
        int k;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= s;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20) begin
            fail_count++;
            conclude();
        end
    endtask : wb
    function automatic rx_status_pkg::frame_end_t mk(input logic [47:0] d, input logic [7:0] f);
        mk = {d, f[7], 16'hA5C3, f[6:0]};
    endfunction : mk
    task automatic frame(input int n, input logic [47:0] d, input logic [7:0] f, input logic pe);
        int k;
        mac.send(n, mk(d, f), pe);
        k = 0;
        while (status_out.valid !== 1'b1 && k < 8) begin
            @(negedge clk);
            k++;
        end
        st = status_out;
        if (k >= 8) begin
            fail_count++;
            conclude();
        end
    endtask : frame
    task automatic s_regs();
        wb(1'b0, rx_status_pkg::CTRL_OFFSET, '0);
        cmp("ctrl", rx_status_pkg::CTRL_RESET, q);
        wb(1'b1, rx_status_pkg::CTRL_OFFSET, 32'hFFFF_FFFF, 4'h1);
        wb(1'b0, rx_status_pkg::CTRL_OFFSET, '0);
        cmp("ctrl_sel", rx_status_pkg::CTRL_RESET | 32'h0000_0003, q);
        wb(1'b1, rx_status_pkg::CTRL_OFFSET, rx_status_pkg::CTRL_RESET);
        wb(1'b1, rx_status_pkg::LAST_WORD_OFFSET, 32'hFFFF_FFFF);
        wb(1'b0, rx_status_pkg::LAST_WORD_OFFSET, '0);
        cmp("last_word", '0, q);
        wb(1'b0, 5'h14, '0);
        cmp("unmapped", '0, q);
    endtask : s_regs
    task automatic s_addr();
        frame(80, UC, 8'h00, 1'b0);
        cmp("unicast", 32'h0000_8000, st.word & 32'h0300_8000);
        frame(80, MC, 8'h00, 1'b0);
        cmp("multicast", 32'h0100_0000, st.word & 32'h0300_8000);
        frame(80, BC, 8'h00, 1'b0);
        cmp("broadcast", 32'h0200_0000, st.word & 32'h0300_8000);
    endtask : s_addr
    task automatic s_len();
        frame(64, UC, 8'h00, 1'b0);
        cmp("len64", 32'h0000_0040, st.word & 32'h0010_3FFF);
        frame(63, UC, 8'h00, 1'b0);
        cmp("runt", 32'h0010_003F, st.word & 32'h0010_3FFF);
        cmp("runt_drop", 1, st.drop);
        wb(1'b1, rx_status_pkg::CTRL_OFFSET, rx_status_pkg::CTRL_RESET | 32'h0000_0003);
        frame(63, UC, 8'h00, 1'b0);
        cmp("runt_strip", 32'h0010_003B, st.word & 32'h0010_3FFF);
        cmp("runt_keep", 0, st.drop);
        frame(100, UC, 8'h00, 1'b0);
        cmp("strip", 32'h0000_0060, st.word & 32'h0010_3FFF);
        wb(1'b1, rx_status_pkg::CTRL_OFFSET, rx_status_pkg::CTRL_RESET);
    endtask : s_len
    task automatic s_err();
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            gigabit_mode <= em[i][1];
            frame(80, UC, ef[i], em[i][2]);
            cmp("err_bits", ew[i], st.word & 32'h807F_4000);
            cmp("err_drop", em[i][0], st.drop);
        end
        @(posedge clk);
        gigabit_mode <= 1'b0;
    endtask : s_err
    task automatic s_long();
        wb(1'b1, rx_status_pkg::CTRL_OFFSET, 32'h0046_0000);
        frame(71, UC, 8'h00, 1'b0);
        cmp("long", 32'h0048_0047, st.word & 32'h0048_3FFF);
        frame(70, UC, 8'h00, 1'b0);
        cmp("at_max", 32'h0000_0046, st.word & 32'h0048_3FFF);
        wb(1'b1, rx_status_pkg::CTRL_OFFSET, rx_status_pkg::CTRL_RESET);
    endtask : s_long
    task automatic s_vlan();
        frame(80, UC, 8'h80, 1'b0);
        cmp("vlan_word", 32'h0080_8050, st.word & 32'h03FF_FFFF);
        cmp("vlan_tag", 32'h0000_A5C3, st.vlan_tag);
        wb(1'b0, rx_status_pkg::LAST_WORD_OFFSET, '0);
        cmp("last_word", 32'h0080_8050, q & 32'h03FF_FFFF);
    endtask : s_vlan
    task automatic s_irq();
        cmp("irq_masked", 0, irq);
        wb(1'b1, rx_status_pkg::INT_MASK_OFFSET, 32'h0000_0007);
        repeat (2) @(negedge clk);
        cmp("irq_on", 1, irq);
        wb(1'b0, rx_status_pkg::INT_STATUS_OFFSET, '0);
        cmp("int_status", 32'h0000_0007, q & 32'h0000_0007);
        wb(1'b1, rx_status_pkg::INT_STATUS_OFFSET, 32'h0000_0007);
        repeat (2) @(negedge clk);
        cmp("irq_clear", 0, irq);
        frame(80, UC, 8'h00, 1'b0);
        repeat (2) @(negedge clk);
        cmp("irq_done", 1, irq);
        wb(1'b0, rx_status_pkg::INT_STATUS_OFFSET, '0);
        cmp("done_only", 32'h0000_0001, q & 32'h0000_0007);
        wb(1'b0, rx_status_pkg::INT_MASK_OFFSET, '0);
        cmp("int_mask", 32'h0000_0007, q);
        wb(1'b1, rx_status_pkg::FRAME_COUNT_OFFSET, 32'hFFFF_FFFF);
        wb(1'b0, rx_status_pkg::FRAME_COUNT_OFFSET, '0);
        cmp("frame_count", 32'h0000_0014, q);
    endtask : s_irq
    initial begin
        srst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 5'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = '0;
        gigabit_mode = 1'b0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        s_regs();
        s_addr();
        s_len();
        s_err();
        s_long();
        s_vlan();
        s_irq();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
